// *** hcu_top.v ***
// What this block does
// - source switch picks display or switch parameters
// - new firmware with source on ignores switches
// - display entry allows addresses zero to 31
// - occupied addresses shown with asterisk prefix
// - entry only while waiting, jog plus second
// - plus minus step value within range
// - automatic key advances and stores previous value
// - no entry: stored values, else defaults; here reset clears the stored copy, so defaults apply
// - receive circle 1 to 16, default two
// - other global data numbers are fixed
// - first two input bytes reserved, zero
// - key bytes base plus two to four
// - byte five: ack, key switch, override code
// - ack set after display data accepted
//
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "hcu_regs.vh"
module hcu_top (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire [3:0] config_switch_bank_a,
  input wire [3:0] address_switch_bank,
  input wire [23:0] key_in,
  input wire key_switch,
  input wire [4:0] override_code,
  output reg baud_fast,
  output reg [4:0] bus_addr,
  output reg [1:0] idle_sel,
  output reg entry_mode,
  output reg display_star,
  output reg [47:0] input_image
);
  // key positions (index = key number - 1)
  localparam K_JOG = 0;
  localparam K_SECOND = 1;
  localparam K_AUTO = 5;
  localparam K_PLUS = 21;
  localparam K_MINUS = 23;
  // one-hot entry states: idle plus one per adjustable parameter
  localparam S_IDLE = 4'b0001;
  localparam S_CIRC = 4'b0010;
  localparam S_BAUD = 4'b0100;
  localparam S_ADDR = 4'b1000;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // step a value up or down, clamped at its limits
  function [4:0] step_clamp;
    input [4:0] v;
    input up;
    input dn;
    input [4:0] lo;
    input [4:0] hi;
    begin
      step_clamp = v;
      if (up && !dn && v < hi) begin
        step_clamp = v + 5'h01;
      end else if (dn && !up && v > lo) begin
        step_clamp = v - 5'h01;
      end
    end
  endfunction

  // a write data phase aimed at one register offset
  function wr_hit;
    input pend;
    input wr;
    input [11:0] a;
    input [11:0] target;
    begin
      wr_hit = pend && wr && (a == target);
    end
  endfunction

  // switch one is address bit 3 (bit 4 stays zero), on meaning one
  function [4:0] sw_addr;
    input [3:0] sw;
    begin
      sw_addr = {1'b0, sw[0], sw[1], sw[2], sw[3]};
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [31:0] ctrl_r;
  reg ack_r;
  reg [3:0] st_r;
  reg [4:0] circ_r;
  reg baud_r;
  reg [4:0] addr_r;
  reg [31:0] occ_r;
  reg [10:0] nvm_r;
  reg nvm_valid_r;
  reg [23:0] key_prev_r;
  reg loaded_r;
  reg bus_pend_r;
  reg bus_wr_r;
  reg [11:0] bus_addr_r;
  wire [23:0] key_rise;
  wire gd_wait;
  wire use_display;
  wire combo;

  // a key counts once per press; holding it does not repeat the step
  assign key_rise = key_in & ~key_prev_r;
  assign gd_wait = ctrl_r[`HCU_CTRL_GD_WAIT];
  // source switch is bank a switch 4 (bit 3)
  assign use_display = config_switch_bank_a[3];
  assign combo = key_in[K_JOG] & key_in[K_SECOND] & gd_wait;

  // ----------------------------------------
  // ahb-lite slave, zero wait states
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_pend_r <= 1'b0;
      bus_wr_r <= 1'b0;
      bus_addr_r <= 12'h000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      // hsize is not decoded: every register is one whole word
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready) begin
        bus_pend_r <= hsel & htrans[1];
        bus_wr_r <= hwrite;
        bus_addr_r <= haddr;
      end
    end
  end

  // write side: ctrl word, occupancy word and ack that copies the ctrl ack bit one edge late
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= 32'h00000001;
      ack_r <= 1'b0;
      occ_r <= 32'h00000000;
    end else begin
      // software owns the waiting flag and clears it once the first telegram is in
      if (wr_hit(bus_pend_r, bus_wr_r, bus_addr_r, `HCU_ADDR_CTRL)) begin
        ctrl_r <= hwdata;
      end
      if (wr_hit(bus_pend_r, bus_wr_r, bus_addr_r, `HCU_ADDR_OCC)) begin
        occ_r <= hwdata;
      end
      // ack follows the ctrl ack bit; it stays set until software clears that bit
      ack_r <= ctrl_r[`HCU_CTRL_ACK];
    end
  end

  // read data registered one edge after the address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      if (haddr == `HCU_ADDR_CTRL) begin
        hrdata <= ctrl_r;
      end else if (haddr == `HCU_ADDR_STATUS) begin
        // status packs the effective settings and the one-hot dialogue state
        hrdata <= {19'h00000, st_r, entry_mode, baud_fast, idle_sel, bus_addr};
      end else if (haddr == `HCU_ADDR_PARAM) begin
        hrdata <= {7'h00, `HCU_TX_OBJ_NUM, `HCU_TX_ID_NUM, `HCU_TX_CIRCLE,
                   `HCU_RX_OBJ_NUM, circ_r};
      end else if (haddr == `HCU_ADDR_IMG_LO) begin
        hrdata <= input_image[31:0];
      end else if (haddr == `HCU_ADDR_IMG_HI) begin
        hrdata <= {16'h0000, input_image[47:32]};
      end else if (haddr == `HCU_ADDR_OCC) begin
        hrdata <= occ_r;
      end else if (haddr == `HCU_ADDR_NVM) begin
        hrdata <= {20'h00000, nvm_valid_r, nvm_r};
      end else begin
        // unmapped offsets read as zero and still answer okay
        hrdata <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------
  // parameter entry dialogue
  // ----------------------------------------
  // non-volatile copy modelled as a register that survives only soft state;
  // a real part would back it with flash, here it is written per advance
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= S_IDLE;
      circ_r <= `HCU_RX_CIRCLE_DEF;
      baud_r <= `HCU_BAUD_DEF;
      addr_r <= `HCU_ADDR_DEF;
      nvm_r <= 11'h000;
      nvm_valid_r <= 1'b0;
      key_prev_r <= 24'h000000;
      loaded_r <= 1'b0;
    end else begin
      key_prev_r <= key_in;
      // reset clears the stored copy, so the load one edge after reset always keeps the defaults
      if (!loaded_r) begin
        loaded_r <= 1'b1;
        // take stored values, defaults stay if none are stored
        if (nvm_valid_r) begin
          circ_r <= nvm_r[4:0];
          baud_r <= nvm_r[5];
          addr_r <= {1'b0, nvm_r[9:6]} | {nvm_r[10], 4'h0};
        end
      end
      // only one parameter is open at a time, so plus and minus touch just that one
      case (st_r)
        S_IDLE: begin
          if (combo) begin
            st_r <= S_CIRC;
          end
        end
        S_CIRC: begin
          circ_r <= step_clamp(circ_r, key_rise[K_PLUS], key_rise[K_MINUS],
                               `HCU_RX_CIRCLE_MIN, `HCU_RX_CIRCLE_MAX);
          if (key_rise[K_AUTO]) begin
            st_r <= S_BAUD;
            nvm_r[4:0] <= circ_r;
            nvm_valid_r <= 1'b1;
          end
        end
        S_BAUD: begin
          // only two rates, plus picks fast, minus slow
          if (key_rise[K_PLUS]) begin
            baud_r <= 1'b1;
          end else if (key_rise[K_MINUS]) begin
            baud_r <= 1'b0;
          end
          if (key_rise[K_AUTO]) begin
            st_r <= S_ADDR;
            nvm_r[5] <= baud_r;
          end
        end
        S_ADDR: begin
          addr_r <= step_clamp(addr_r, key_rise[K_PLUS], key_rise[K_MINUS],
                               `HCU_ADDR_MIN, `HCU_ADDR_MAX);
          if (key_rise[K_AUTO]) begin
            st_r <= S_IDLE;
            nvm_r[10:6] <= {addr_r[4], addr_r[3:0]};
          end
        end
        default: begin
          st_r <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // effective bus parameters and image
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      baud_fast <= `HCU_BAUD_DEF;
      bus_addr <= `HCU_ADDR_DEF;
      idle_sel <= 2'h0;
      entry_mode <= 1'b0;
      display_star <= 1'b0;
      input_image <= 48'h000000000000;
    end else begin
      entry_mode <= (st_r != S_IDLE);
      // asterisk when the address on show is held by another node
      display_star <= (st_r == S_ADDR) && occ_r[addr_r];
      // the switches are read live; a change takes effect on the next edge
      if (use_display) begin
        baud_fast <= baud_r;
        bus_addr <= addr_r;
      end else begin
        baud_fast <= config_switch_bank_a[2];
        bus_addr <= sw_addr(address_switch_bank);
      end
      // newer firmware in display mode ignores the idle switches
      if (use_display && ctrl_r[`HCU_CTRL_NEWFW]) begin
        idle_sel <= 2'h0;
      end else begin
        idle_sel <= (config_switch_bank_a[1:0] == 2'b10) ? `HCU_IDLE_100MS : 2'h0;
      end
      // bytes base..base+5, base in the low bits
      input_image <= {ack_r, key_switch, 1'b0, override_code,
                      key_in[23:20], 4'h0, key_in[15:8], key_in[7:0],
                      16'h0000};
    end
  end
endmodule
`default_nettype wire

// *** hcu_regs.vh ***
`ifndef HCU_REGS_VH
`define HCU_REGS_VH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define HCU_ADDR_CTRL 12'h000
`define HCU_ADDR_STATUS 12'h004
`define HCU_ADDR_PARAM 12'h008
`define HCU_ADDR_IMG_LO 12'h00c
`define HCU_ADDR_IMG_HI 12'h010
`define HCU_ADDR_OCC 12'h014
`define HCU_ADDR_NVM 12'h018
// ----------------------------------------
// fields and values
// ----------------------------------------
`define HCU_CTRL_GD_WAIT 0
`define HCU_CTRL_ACK 1
`define HCU_CTRL_NEWFW 2
`define HCU_RX_CIRCLE_DEF 5'h02
`define HCU_RX_CIRCLE_MIN 5'h01
`define HCU_RX_CIRCLE_MAX 5'h10
`define HCU_ADDR_DEF 5'h0f
`define HCU_ADDR_MIN 5'h00
`define HCU_ADDR_MAX 5'h1f
`define HCU_BAUD_DEF 1'b1
`define HCU_RX_ID_NUM 5'h01
`define HCU_RX_OBJ_NUM 5'h01
`define HCU_TX_CIRCLE 5'h02
`define HCU_TX_ID_NUM 5'h02
`define HCU_TX_OBJ_NUM 5'h01
`define HCU_IDLE_100MS 2'h1
`define HCU_NVM_MAGIC 4'ha
`endif

// *** hcu_props.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------
// port checks
// ----------------
module hcu_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] config_switch_bank_a,
  input wire logic [3:0] address_switch_bank,
  input wire logic [23:0] key_in,
  input wire logic key_switch,
  input wire logic [4:0] override_code,
  input wire logic baud_fast,
  input wire logic [4:0] bus_addr,
  input wire logic [1:0] idle_sel,
  input wire logic entry_mode,
  input wire logic [47:0] input_image
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire sw_mode = !config_switch_bank_a[3] && !entry_mode;
  // image follows its inputs one edge late
  a_resv_zero: assert property (input_image[15:0] == 16'h0000)
    else $error("reserved bytes not zero");
  a_keys_low: assert property (input_image[31:16] == $past(key_in[15:0]))
    else $error("key bytes wrong");
  a_keys_high: assert property (input_image[39:36] == $past(key_in[23:20]))
    else $error("upper keys wrong");
  a_ctl_byte: assert property ({input_image[46], input_image[44:40]} ==
    {$past(key_switch), $past(override_code)}) else $error("switch byte wrong");
  // switch mode settings land one edge after the switches
  a_baud_sw: assert property (sw_mode |=> baud_fast == $past(config_switch_bank_a[2]))
    else $error("baud not from switch");
  a_idle_sw: assert property (sw_mode |=> idle_sel ==
    (($past(config_switch_bank_a[1:0]) == 2'b10) ? 2'h1 : 2'h0)) else $error("idle wrong");
  a_addr_sw: assert property (sw_mode |=> bus_addr == {1'b0, $past(address_switch_bank[0]),
    $past(address_switch_bank[1]), $past(address_switch_bank[2]),
    $past(address_switch_bank[3])}) else $error("address not from switches");
  a_entry_gate: assert property ($rose(entry_mode) |->
    $past(key_in[1:0]) == 2'b11 || $past(key_in[1:0], 2) == 2'b11) else $error("bad entry");
  c_entry: cover property ($rose(entry_mode));
  c_ack: cover property ($rose(input_image[47]));
  c_fast: cover property (sw_mode && baud_fast);
endmodule
bind hcu_top hcu_props u_props (.hclk(hclk), .hresetn(hresetn),
  .config_switch_bank_a(config_switch_bank_a), .address_switch_bank(address_switch_bank),
  .key_in(key_in), .key_switch(key_switch), .override_code(override_code),
  .baud_fast(baud_fast), .bus_addr(bus_addr), .idle_sel(idle_sel),
  .entry_mode(entry_mode), .input_image(input_image));
`default_nettype wire

// *** hcu_plc_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------
// controller global data settings
// ----------------
module hcu_plc_model #(
  parameter logic [4:0] RX_CIRCLE = 5'h02,
  parameter logic [4:0] RX_OBJ = 5'h01,
  parameter logic [4:0] TX_CIRCLE = 5'h02,
  parameter logic [4:0] TX_ID = 5'h02,
  parameter logic [4:0] TX_OBJ = 5'h01
) (
  output wire logic [31:0] gd_word
);
  // must mirror the unit exactly, otherwise no telegram is exchanged
  assign gd_word = {7'h00, TX_OBJ, TX_ID, TX_CIRCLE, RX_OBJ, RX_CIRCLE};
endmodule
`default_nettype wire

// *** handheld_config_and_input_image_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "hcu_regs.vh"
// ----------------
// bench
// ----------------
module handheld_config_and_input_image_tb;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rd_ph = 0, ksw = 0;
  logic [11:0] haddr = 0;
  logic [1:0] htrans = 0, idle_sel;
  logic [2:0] hsize = 3'h2;
  logic [3:0] cfg = 4'h8, asw = 0;
  logic [4:0] ov = 0, bus_addr;
  logic [23:0] key_in = 0;
  logic [31:0] hwdata = 0, hrdata, gd_word, r, ex_q[$], em_q[$];
  logic [47:0] img;
  logic hreadyout, hresp, baud_fast, entry_mode, display_star;
  int fail_count = 0, num_checks = 0;
  hcu_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .config_switch_bank_a(cfg),
    .address_switch_bank(asw), .key_in(key_in), .key_switch(ksw), .override_code(ov),
    .baud_fast(baud_fast), .bus_addr(bus_addr), .idle_sel(idle_sel),
    .entry_mode(entry_mode), .display_star(display_star), .input_image(img));
  hcu_plc_model u_plc (.gd_word(gd_word));
  always #50 hclk = ~hclk;
  task summarize;
    if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task cmp(input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("MISMATCH hrdata exp %h got %h", e, g);
      fail_count++;
    end
  endtask
  task cmp_star(input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      $display("MISMATCH display_star exp %b got %b", e, g);
      fail_count++;
    end
  endtask
  // bounded wait for hready, a hang ends the run
  task wt;
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (hreadyout !== 1'b1) begin
      fail_count++;
      summarize;
    end
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wt;
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= !w;
    ex_q.push_back(d & m);
    em_q.push_back(m);
    wt;
    rd_ph <= 1'b0;
  endtask
  task press(input int b);
    key_in[b] <= 1'b1;
    repeat (3) @(posedge hclk);
    key_in[b] <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask
  // watcher: each completed read is matched against the oldest note
  always @(posedge hclk) begin
    if (rd_ph && hreadyout) begin
      cmp(ex_q[0], hrdata & em_q[0]);
      ex_q.delete(0);
      em_q.delete(0);
    end
    else if (hsel && hwrite && hreadyout && htrans == 2'h0 && em_q.size() > 0) begin
      ex_q.delete(0);
      em_q.delete(0);
    end
  end
  initial begin
    r = $urandom(32'h32dd);
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    bus(0, `HCU_ADDR_STATUS, 32'h08f, 32'h19f);
    bus(0, `HCU_ADDR_PARAM, gd_word, 32'h1ffffff);
    bus(0, 12'h100, 32'h0, 32'hffffffff);
    bus(1, `HCU_ADDR_CTRL, 32'h0, 32'h0);
    repeat (4) begin
      r = $urandom;
      key_in <= r[23:0];
      ksw <= r[24];
      ov <= r[29:25];
      repeat (2) @(posedge hclk);
      bus(0, `HCU_ADDR_IMG_LO, {key_in[15:0], 16'h0}, 32'hffffffff);
      bus(0, `HCU_ADDR_IMG_HI, {ksw, 1'b0, ov, key_in[23:20], 4'h0} << 4'h0, 32'h5ff0);
    end
    key_in <= 24'h3;
    repeat (3) @(posedge hclk);
    bus(0, `HCU_ADDR_STATUS, 32'h0, 32'h100);
    key_in <= 24'h0;
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      cfg <= {1'b0, r[0], i[1:0]};
      asw <= r[4:1];
      repeat (2) @(posedge hclk);
      bus(0, `HCU_ADDR_STATUS, {cfg[2], (cfg[1:0] == 2'b10) ? 2'h1 : 2'h0, 1'b0,
        asw[0], asw[1], asw[2], asw[3]}, 32'hff);
    end
    bus(1, `HCU_ADDR_CTRL, 32'h2, 32'h0);
    repeat (4) @(posedge hclk);
    bus(0, `HCU_ADDR_IMG_HI, 32'h8000, 32'h8000);
    bus(1, `HCU_ADDR_CTRL, 32'h1, 32'h0);
    repeat (4) @(posedge hclk);
    bus(0, `HCU_ADDR_IMG_HI, 32'h0, 32'h8000);
    cfg <= 4'h8;
    key_in <= 24'h3;
    repeat (3) @(posedge hclk);
    key_in <= 24'h0;
    repeat (3) @(posedge hclk);
    bus(0, `HCU_ADDR_STATUS, 32'h100, 32'h100);
    repeat (16) press(21);
    press(5);
    bus(0, `HCU_ADDR_PARAM, 32'h10, 32'h1f);
    bus(0, `HCU_ADDR_NVM, 32'h810, 32'hfff);
    press(23);
    press(5);
    bus(1, `HCU_ADDR_OCC, 32'h4000, 32'h0);
    repeat (2) @(posedge hclk);
    cmp_star(1'b0, display_star);
    press(23);
    cmp_star(1'b1, display_star);
    repeat (18) press(21);
    cmp_star(1'b0, display_star);
    press(5);
    bus(0, `HCU_ADDR_STATUS, 32'h01f, 32'h19f);
    bus(0, `HCU_ADDR_NVM, 32'hfd0, 32'hfff);
    cfg <= 4'ha;
    bus(1, `HCU_ADDR_CTRL, 32'h4, 32'h0);
    repeat (2) @(posedge hclk);
    bus(0, `HCU_ADDR_STATUS, 32'h0, 32'h60);
    bus(1, `HCU_ADDR_CTRL, 32'h0, 32'h0);
    repeat (2) @(posedge hclk);
    bus(0, `HCU_ADDR_STATUS, 32'h20, 32'h60);
    repeat (2) @(posedge hclk);
    summarize;
  end
endmodule
`default_nettype wire
